// ---- verilog/obp_regs.sv ----
// Output-driver power-down, global power-down keep mask and sync/ref regs
`timescale 1ns/1ps
`include "obp_defs.svh"

module obp_regs
	import obp_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [`OBP_ADDR_W-1:0] reg_addr,
	input wire logic [`OBP_DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [`OBP_DATA_W-1:0] reg_rdata,
	output logic reg_rdata_valid,
	input wire logic whole_device_powerdown,
	input wire logic [2:0] output_mode,
	input wire logic serial_input_clock_enable_main,
	input wire logic serial_input_clock_enable_aux,
	input wire logic data_clock_out_powerdown,
	output logic [`OBP_OFF_BITS_W-1:0] output_driver_off_bits,
	output logic [`OBP_DATA_PINS-1:0] data_pin_driver_off,
	output logic frame_clock_out_driver_off,
	output logic serial_input_clock_receiver_on,
	output logic data_clock_out_driver_off,
	output logic sample_clock_buffer_off,
	output logic reference_amplifier_off,
	output logic bandgap_off,
	output logic core_off,
	output logic wake_complete,
	output logic serial_mode,
	output logic serial_clock_pin_conflict,
	output logic output_mode_legal,
	output logic pin_sync_select,
	output logic register_sync_trigger,
	output logic register_sync_enable,
	output logic register_sync_pulse,
	output logic reference_control_source,
	output logic [1:0] reference_select,
	output logic single_ended_clock_enable
);

	logic [`OBP_DATA_W-1:0] output_buffer_disable_low;
	logic [`OBP_DATA_W-1:0] output_buffer_disable_mid;
	logic [`OBP_DATA_W-1:0] output_buffer_disable_high;
	logic [`OBP_DATA_W-1:0] global_powerdown_keep_mask;
	logic [`OBP_DATA_W-1:0] sync_reference_control;
	logic [`OBP_DATA_W-1:0] next_output_buffer_disable_low;
	logic [`OBP_DATA_W-1:0] next_output_buffer_disable_mid;
	logic [`OBP_DATA_W-1:0] next_output_buffer_disable_high;
	logic [`OBP_DATA_W-1:0] next_global_powerdown_keep_mask;
	logic [`OBP_DATA_W-1:0] next_sync_reference_control;
	logic [`OBP_DATA_W-1:0] next_reg_rdata;
	logic next_reg_rdata_valid;

	logic next_sample_clock_buffer_off;
	logic next_reference_amplifier_off;
	logic next_bandgap_off;
	logic next_core_off;
	logic next_register_sync_pulse;
	logic next_serial_clock_pin_conflict;
	logic next_serial_mode;
	logic next_output_mode_legal;
	logic next_serial_input_clock_receiver_on;
	logic next_data_clock_out_driver_off;
	logic sync_trigger_seen;
	logic next_sync_trigger_seen;

	// Pin number to position in the 24-bit off vector
	function automatic logic [4:0] obp_pin_source(input int pin);
		logic [4:0] src;
		src = `OBP_SRC_D0;
		case (pin)
			0: src = `OBP_SRC_D0;
			1: src = `OBP_SRC_D1;
			2: src = `OBP_SRC_D2;
			3: src = `OBP_SRC_D3;
			4: src = `OBP_SRC_D4;
			5: src = `OBP_SRC_D5;
			6: src = `OBP_SRC_D6;
			7: src = `OBP_SRC_D7;
			8: src = `OBP_SRC_D8;
			9: src = `OBP_SRC_D9;
			10: src = `OBP_SRC_D10;
			11: src = `OBP_SRC_D11;
			12: src = `OBP_SRC_D12;
			13: src = `OBP_SRC_D13;
			14: src = `OBP_SRC_D14;
			15: src = `OBP_SRC_D15;
			default: src = `OBP_SRC_D0;
		endcase
		return src;
	endfunction : obp_pin_source

	// Register writes; reserved bits stored but unused
	always_comb begin
		next_output_buffer_disable_low = output_buffer_disable_low;
		next_output_buffer_disable_mid = output_buffer_disable_mid;
		next_output_buffer_disable_high = output_buffer_disable_high;
		next_global_powerdown_keep_mask = global_powerdown_keep_mask;
		next_sync_reference_control = sync_reference_control;
		if (reg_write) begin
			case (reg_addr)
				`OBP_ADDR_OFF_LOW: begin
					next_output_buffer_disable_low = reg_wdata;
				end
				`OBP_ADDR_OFF_MID: begin
					next_output_buffer_disable_mid = reg_wdata;
				end
				`OBP_ADDR_OFF_HIGH: begin
					next_output_buffer_disable_high = reg_wdata;
				end
				`OBP_ADDR_KEEP_MASK: begin
					next_global_powerdown_keep_mask = reg_wdata;
				end
				`OBP_ADDR_SYNC_REF: begin
					next_sync_reference_control = reg_wdata;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			output_buffer_disable_low <= `OBP_RESET_BYTE;
			output_buffer_disable_mid <= `OBP_RESET_BYTE;
			output_buffer_disable_high <= `OBP_RESET_BYTE;
			global_powerdown_keep_mask <= `OBP_RESET_BYTE;
			sync_reference_control <= `OBP_RESET_BYTE;
		end else if (ce) begin
			output_buffer_disable_low <= next_output_buffer_disable_low;
			output_buffer_disable_mid <= next_output_buffer_disable_mid;
			output_buffer_disable_high <= next_output_buffer_disable_high;
			global_powerdown_keep_mask <= next_global_powerdown_keep_mask;
			sync_reference_control <= next_sync_reference_control;
		end
	end

	// Read data holds until the next read; same-cycle write reads old
	always_comb begin
		next_reg_rdata = reg_rdata;
		next_reg_rdata_valid = 1'b0;
		if (reg_read) begin
			next_reg_rdata_valid = 1'b1;
			case (reg_addr)
				`OBP_ADDR_OFF_LOW: begin
					next_reg_rdata = output_buffer_disable_low;
				end
				`OBP_ADDR_OFF_MID: begin
					next_reg_rdata = output_buffer_disable_mid;
				end
				`OBP_ADDR_OFF_HIGH: begin
					next_reg_rdata = output_buffer_disable_high;
				end
				`OBP_ADDR_KEEP_MASK: begin
					next_reg_rdata = global_powerdown_keep_mask;
				end
				`OBP_ADDR_SYNC_REF: begin
					next_reg_rdata = sync_reference_control;
				end
				default: begin
					next_reg_rdata = `OBP_READ_NONE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= `OBP_READ_NONE;
			reg_rdata_valid <= 1'b0;
		end else if (ce) begin
			reg_rdata <= next_reg_rdata;
			reg_rdata_valid <= next_reg_rdata_valid;
		end
	end

	assign output_driver_off_bits = {output_buffer_disable_high,
		output_buffer_disable_mid, output_buffer_disable_low};

	genvar g;
	generate
		for (g = 0; g < `OBP_DATA_PINS; g++) begin : gen_pin
			assign data_pin_driver_off[g] =
				output_driver_off_bits[obp_pin_source(g)];
		end
	endgenerate
	assign frame_clock_out_driver_off =
		output_driver_off_bits[`OBP_SRC_FRAME];

	// Sync/reference fields go straight from the register
	assign pin_sync_select = sync_reference_control[`OBP_PIN_SYNC_BIT];
	assign register_sync_trigger = sync_reference_control[`OBP_REG_SYNC_BIT];
	assign register_sync_enable =
		sync_reference_control[`OBP_REG_SYNC_EN_BIT];
	assign reference_control_source =
		sync_reference_control[`OBP_REF_SRC_BIT];
	assign reference_select =
		sync_reference_control[`OBP_REF_SEL_HI:`OBP_REF_SEL_LO];
	assign single_ended_clock_enable =
		sync_reference_control[`OBP_SE_CLK_BIT];

	// Power control, registered one cycle behind the request
	always_comb begin
		next_core_off = whole_device_powerdown;
		next_sample_clock_buffer_off = whole_device_powerdown &
			~global_powerdown_keep_mask[`OBP_KEEP_CLKBUF_BIT];
		next_reference_amplifier_off = whole_device_powerdown &
			~global_powerdown_keep_mask[`OBP_KEEP_REFAMP_BIT];
		// Inverted sense: set means the bandgap goes down too
		next_bandgap_off = whole_device_powerdown &
			global_powerdown_keep_mask[`OBP_BANDGAP_BIT];
		// Receiver enables live elsewhere, off bits never reach them
		next_serial_input_clock_receiver_on = serial_input_clock_enable_main |
			serial_input_clock_enable_aux;
		next_data_clock_out_driver_off = data_clock_out_powerdown;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			core_off <= 1'b0;
			sample_clock_buffer_off <= 1'b0;
			reference_amplifier_off <= 1'b0;
			bandgap_off <= 1'b0;
			serial_input_clock_receiver_on <= 1'b0;
			data_clock_out_driver_off <= 1'b0;
		end else if (ce) begin
			core_off <= next_core_off;
			sample_clock_buffer_off <= next_sample_clock_buffer_off;
			reference_amplifier_off <= next_reference_amplifier_off;
			bandgap_off <= next_bandgap_off;
			serial_input_clock_receiver_on <=
				next_serial_input_clock_receiver_on;
			data_clock_out_driver_off <= next_data_clock_out_driver_off;
		end
	end

	// Mode decode and the shared serial clock pin check
	always_comb begin
		next_output_mode_legal = 1'b1;
		next_serial_mode = 1'b0;
		unique case (output_mode)
			OBP_SINGLE_RATE_PARALLEL_MODE,
			OBP_DOUBLE_RATE_PARALLEL_MODE: next_serial_mode = 1'b0;
			OBP_SERIAL_TWO_WIRE_MODE,
			OBP_SERIAL_ONE_WIRE_MODE,
			OBP_SERIAL_HALF_WIRE_MODE: next_serial_mode = 1'b1;
			default: next_output_mode_legal = 1'b0;
		endcase
		// Shared pin would fight the incoming serial clock
		next_serial_clock_pin_conflict = next_serial_mode &
			~output_buffer_disable_low[`OBP_SERIAL_CLK_BIT];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			output_mode_legal <= 1'b1;
			serial_mode <= 1'b0;
			serial_clock_pin_conflict <= 1'b0;
		end else if (ce) begin
			output_mode_legal <= next_output_mode_legal;
			serial_mode <= next_serial_mode;
			serial_clock_pin_conflict <= next_serial_clock_pin_conflict;
		end
	end

	// Every change of the trigger bit counts, not just rising
	always_comb begin
		next_sync_trigger_seen = register_sync_trigger;
		next_register_sync_pulse = register_sync_enable &
			(register_sync_trigger ^ sync_trigger_seen);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_trigger_seen <= 1'b0;
			register_sync_pulse <= 1'b0;
		end else if (ce) begin
			sync_trigger_seen <= next_sync_trigger_seen;
			register_sync_pulse <= next_register_sync_pulse;
		end
	end

	obp_wake_timer u_wake (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.powerdown(core_off),
		.bandgap_off(bandgap_off),
		.awake(wake_complete)
	);

endmodule : obp_regs

// ---- verilog/obp_defs.svh ----
// Offsets, field positions, reset values and timing for the power/mask slice
`ifndef OBP_DEFS_SVH
`define OBP_DEFS_SVH

`define OBP_ADDR_W 8
`define OBP_DATA_W 8
`define OBP_OFF_BITS_W 24
`define OBP_DATA_PINS 16

`define OBP_ADDR_OFF_LOW 8'h0A
`define OBP_ADDR_OFF_MID 8'h0B
`define OBP_ADDR_OFF_HIGH 8'h0C
`define OBP_ADDR_KEEP_MASK 8'h0D
`define OBP_ADDR_SYNC_REF 8'h0E

`define OBP_RESET_BYTE 8'h00
`define OBP_READ_NONE 8'h00

// Keep-mask fields
`define OBP_KEEP_CLKBUF_BIT 3
`define OBP_KEEP_REFAMP_BIT 2
`define OBP_BANDGAP_BIT 1

// Sync/reference fields
`define OBP_PIN_SYNC_BIT 7
`define OBP_REG_SYNC_BIT 6
`define OBP_REG_SYNC_EN_BIT 5
`define OBP_REF_SRC_BIT 3
`define OBP_REF_SEL_HI 2
`define OBP_REF_SEL_LO 1
`define OBP_SE_CLK_BIT 0

// Position in the 24-bit off vector of each driver
`define OBP_SRC_D0 5'd0
`define OBP_SRC_D1 5'd1
`define OBP_SRC_D2 5'd2
`define OBP_SRC_D3 5'd3
`define OBP_SRC_D4 5'd4
`define OBP_SRC_D7 5'd7
`define OBP_SRC_D8 5'd8
`define OBP_SRC_FRAME 5'd12
`define OBP_SRC_D15 5'd13
`define OBP_SRC_D14 5'd14
`define OBP_SRC_D13 5'd15
`define OBP_SRC_D12 5'd16
`define OBP_SRC_D11 5'd17
`define OBP_SRC_D5 5'd20
`define OBP_SRC_D6 5'd21
`define OBP_SRC_D9 5'd22
`define OBP_SRC_D10 5'd23
`define OBP_SERIAL_CLK_BIT 3

// Wake-up timing
`define OBP_CLOCK_PERIOD_PS 4000
`define OBP_WAKE_SHORT_NS 1000
`define OBP_WAKE_LONG_NS 4000
`define OBP_WAKE_CNT_W 12
`define OBP_WAKE_CNT_ONE 12'h001
`define OBP_WAKE_CNT_ZERO 12'h000

`endif

// ---- verilog/obp_pkg.sv ----
// Types shared by the power/mask register slice
package obp_pkg;

	typedef enum logic [2:0] {
		OBP_SINGLE_RATE_PARALLEL_MODE = 3'b000,
		OBP_DOUBLE_RATE_PARALLEL_MODE = 3'b001,
		OBP_SERIAL_TWO_WIRE_MODE = 3'b011,
		OBP_SERIAL_ONE_WIRE_MODE = 3'b100,
		OBP_SERIAL_HALF_WIRE_MODE = 3'b101
	} obp_mode_type;

	typedef enum logic [1:0] {
		OBP_RUN = 2'b00,
		OBP_DOWN = 2'b01,
		OBP_WAKE = 2'b10
	} obp_wake_state_type;

endpackage : obp_pkg

// ---- verilog/obp_wake_timer.sv ----
// Wake-up sequencer: longer settling when the bandgap was powered down
`timescale 1ns/1ps
`include "obp_defs.svh"

module obp_wake_timer
	import obp_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic powerdown,
	input wire logic bandgap_off,
	output logic awake
);

	localparam int SHORT_CYC = (`OBP_WAKE_SHORT_NS * 1000
		+ `OBP_CLOCK_PERIOD_PS - 1) / `OBP_CLOCK_PERIOD_PS;
	localparam int LONG_CYC = (`OBP_WAKE_LONG_NS * 1000
		+ `OBP_CLOCK_PERIOD_PS - 1) / `OBP_CLOCK_PERIOD_PS;

	obp_wake_state_type state;
	obp_wake_state_type next_state;
	logic [`OBP_WAKE_CNT_W-1:0] count;
	logic [`OBP_WAKE_CNT_W-1:0] next_count;
	logic bandgap_was_off;
	logic next_bandgap_was_off;
	logic next_awake;

	always_comb begin
		next_state = state;
		next_count = count;
		next_bandgap_was_off = bandgap_was_off;
		unique case (state)
			OBP_RUN: begin
				if (powerdown) begin
					next_state = OBP_DOWN;
					next_bandgap_was_off = bandgap_off;
				end
			end
			OBP_DOWN: begin
				// Bandgap flag drops with the core; wake uses latched copy
				if (powerdown) begin
					next_bandgap_was_off = bandgap_off;
				end
				if (!powerdown) begin
					next_state = OBP_WAKE;
					next_count = bandgap_was_off ?
						`OBP_WAKE_CNT_W'(LONG_CYC) :
						`OBP_WAKE_CNT_W'(SHORT_CYC);
				end
			end
			OBP_WAKE: begin
				if (powerdown) begin
					next_state = OBP_DOWN;
					next_bandgap_was_off = bandgap_off;
				end else if (count == `OBP_WAKE_CNT_ONE) begin
					next_state = OBP_RUN;
					next_count = `OBP_WAKE_CNT_ZERO;
				end else begin
					next_count = count - `OBP_WAKE_CNT_ONE;
				end
			end
			default: begin
				next_state = OBP_RUN;
			end
		endcase
		next_awake = (next_state == OBP_RUN);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= OBP_RUN;
			count <= `OBP_WAKE_CNT_ZERO;
			bandgap_was_off <= 1'b0;
			awake <= 1'b1;
		end else if (ce) begin
			state <= next_state;
			count <= next_count;
			bandgap_was_off <= next_bandgap_was_off;
			awake <= next_awake;
		end
	end

endmodule : obp_wake_timer

// ---- tb/obp_regs_sva.sv ----
// Port-level assertions for the register slice, bound to its top module
`timescale 1ns/1ps
module obp_regs_sva (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic reg_rdata_valid,
	input wire logic whole_device_powerdown,
	input wire logic serial_input_clock_enable_main,
	input wire logic serial_input_clock_enable_aux,
	input wire logic [23:0] output_driver_off_bits,
	input wire logic frame_clock_out_driver_off,
	input wire logic serial_input_clock_receiver_on,
	input wire logic sample_clock_buffer_off,
	input wire logic reference_amplifier_off,
	input wire logic bandgap_off,
	input wire logic core_off,
	input wire logic wake_complete
);
	logic [7:0] mask_q;
	logic pd;
	// Wake length in cycles, far too long for a plain delay
	logic [11:0] wake_cnt;
	logic bg_seen;
	assign pd = whole_device_powerdown;
	// Shadow of the keep mask, since the checker sees only ports
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= 8'h00;
		end else if (ce && reg_write && reg_addr == 8'h0D) begin
			mask_q <= reg_wdata;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wake_cnt <= 12'h000;
			bg_seen <= 1'b0;
		end else if (core_off) begin
			wake_cnt <= 12'h000;
			bg_seen <= bandgap_off;
		end else if (ce && !wake_complete && wake_cnt != 12'hFFF) begin
			wake_cnt <= wake_cnt + 12'h001;
		end
	end
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	sequence held_down;
		ce && pd ##1 ce && pd ##1 ce && pd;
	endsequence
	AST_READ_VALID: assert property (
		ce && reg_read |=> reg_rdata_valid)
		else $error("read gave no valid pulse");
	AST_OFF_LOW: assert property (
		ce && reg_write && reg_addr == 8'h0A
		|=> output_driver_off_bits[7:0] == $past(reg_wdata))
		else $error("low off byte not stored");
	AST_FRAME_PIN: assert property (
		frame_clock_out_driver_off == output_driver_off_bits[12])
		else $error("frame clock driver bit misplaced");
	AST_CLKBUF: assert property (
		ce |=> sample_clock_buffer_off == ($past(pd) && !$past(mask_q[3])))
		else $error("clock buffer power wrong");
	AST_REFAMP: assert property (
		ce |=> reference_amplifier_off == ($past(pd) && !$past(mask_q[2])))
		else $error("reference amplifier power wrong");
	AST_BANDGAP: assert property (
		ce |=> bandgap_off == ($past(pd) && $past(mask_q[1])))
		else $error("bandgap power wrong");
	AST_CORE_OFF: assert property (
		held_down |-> core_off && !wake_complete)
		else $error("core not down");
	AST_WAKE_LONG: assert property (
		$rose(wake_complete) && bg_seen
		|-> wake_cnt >= 12'h3DD && wake_cnt <= 12'h3FB)
		else $error("wake after bandgap off not long");
	AST_WAKE_SHORT: assert property (
		$rose(wake_complete) && !bg_seen
		|-> wake_cnt >= 12'h0F0 && wake_cnt <= 12'h104)
		else $error("wake with bandgap kept not short");
	AST_RECEIVER: assert property (
		ce |=> serial_input_clock_receiver_on == ($past(
		serial_input_clock_enable_main) || $past(serial_input_clock_enable_aux)))
		else $error("receiver enable wrong");
endmodule : obp_regs_sva
bind obp_regs obp_regs_sva chk_i (.clock, .rst_n, .ce, .reg_addr,
	.reg_wdata, .reg_write, .reg_read, .reg_rdata_valid,
	.whole_device_powerdown, .serial_input_clock_enable_main,
	.serial_input_clock_enable_aux, .output_driver_off_bits,
	.frame_clock_out_driver_off, .serial_input_clock_receiver_on,
	.sample_clock_buffer_off, .reference_amplifier_off, .bandgap_off,
	.core_off, .wake_complete);

// ---- tb/obp_host_model.sv ----
// Host model driving the register port of the slice
`timescale 1ns/1ps
module obp_host_model (
	input wire logic clock,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rdata_valid
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge clock);
		#1;
		reg_write = 1'b0;
		// Released data must not look like a held value
		reg_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [8:0] q);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge clock);
		#1;
		reg_read = 1'b0;
		q = {reg_rdata_valid, reg_rdata};
	endtask : rd
	task automatic setup(input logic [2:0] m);
		logic [23:0] v;
		case (m)
			3'b000: v = 24'h0C1E60;
			3'b001: v = 24'h0CFE7F;
			3'b011: v = 24'hFCEFFF;
			3'b100: v = 24'hFDEFFF;
			// No recommended bytes: shared clock pin left driven
			default: v = 24'h000000;
		endcase
		wr(8'h0A, v[7:0]);
		wr(8'h0B, v[15:8]);
		wr(8'h0C, v[23:16]);
	endtask : setup
endmodule : obp_host_model

// ---- tb/obp_regs_tb_top.sv ----
// Self-checking bench for the driver-off and power-down register slice
`timescale 1ns/1ps
module obp_regs_tb_top;
	logic clock, rst_n, ce, reg_write, reg_read, reg_rdata_valid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic whole_device_powerdown, serial_input_clock_enable_main;
	logic serial_input_clock_enable_aux, data_clock_out_powerdown;
	logic [2:0] output_mode, f;
	logic [23:0] output_driver_off_bits;
	logic [15:0] data_pin_driver_off, p;
	logic frame_clock_out_driver_off, serial_input_clock_receiver_on;
	logic data_clock_out_driver_off, sample_clock_buffer_off;
	logic reference_amplifier_off, bandgap_off, core_off, wake_complete;
	logic serial_mode, serial_clock_pin_conflict, output_mode_legal;
	logic pin_sync_select, register_sync_trigger, register_sync_enable;
	logic register_sync_pulse, reference_control_source;
	logic single_ended_clock_enable;
	logic [1:0] reference_select;
	logic [6:0] g;
	logic [8:0] q;
	int err_count, check_count, cycles, i, n;
	typedef struct packed {
		logic [2:0] m;
		logic [23:0] v;
		logic [2:0] e;
	} obp_row_type;
	obp_row_type rows [6];
	obp_regs uut (.clock, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .reg_rdata_valid, .whole_device_powerdown,
		.output_mode, .serial_input_clock_enable_main,
		.serial_input_clock_enable_aux, .data_clock_out_powerdown,
		.output_driver_off_bits, .data_pin_driver_off,
		.frame_clock_out_driver_off, .serial_input_clock_receiver_on,
		.data_clock_out_driver_off, .sample_clock_buffer_off,
		.reference_amplifier_off, .bandgap_off, .core_off, .wake_complete,
		.serial_mode, .serial_clock_pin_conflict, .output_mode_legal,
		.pin_sync_select, .register_sync_trigger, .register_sync_enable,
		.register_sync_pulse, .reference_control_source,
		.reference_select, .single_ended_clock_enable);
	obp_host_model host (.clock, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .reg_rdata_valid);
	task automatic chk(input string s, input logic [23:0] a, b);
		check_count++;
		if (a !== b) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", s, b, a);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : tick
	task automatic pd_case(input logic [7:0] m, input logic [2:0] e,
		input int lo, input int hi);
		host.wr(8'h0D, m);
		whole_device_powerdown = 1'b1;
		tick(4);
		f = {sample_clock_buffer_off, reference_amplifier_off, bandgap_off};
		chk("kept blocks", f, e);
		whole_device_powerdown = 1'b0;
		tick(lo);
		chk("still waking", wake_complete, 1'b0);
		tick(hi);
		chk("awake", wake_complete, 1'b1);
	endtask : pd_case
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Whole run needs about 1400 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		rows[0] = {3'b000, 24'h0C1E60, 3'b001};
		rows[1] = {3'b001, 24'h0CFE7F, 3'b001};
		rows[2] = {3'b011, 24'hFCEFFF, 3'b101};
		rows[3] = {3'b100, 24'hFDEFFF, 3'b101};
		rows[4] = {3'b101, 24'h000000, 3'b111};
		rows[5] = {3'b010, 24'h000000, 3'b000};
		rst_n = 1'b0;
		ce = 1'b1;
		whole_device_powerdown = 1'b0;
		output_mode = 3'b000;
		serial_input_clock_enable_main = 1'b0;
		serial_input_clock_enable_aux = 1'b0;
		data_clock_out_powerdown = 1'b0;
		tick(4);
		rst_n = 1'b1;
		for (i = 0; i < 6; i++) begin
			output_mode = rows[i].m;
			host.setup(rows[i].m);
			tick(2);
			chk("off bits", output_driver_off_bits, rows[i].v);
			chk("frame", frame_clock_out_driver_off, rows[i].v[12]);
			chk("pin d10", data_pin_driver_off[10], rows[i].v[23]);
			p = {rows[i].v[13], rows[i].v[14], rows[i].v[15], rows[i].v[16],
				rows[i].v[17], rows[i].v[23], rows[i].v[22], rows[i].v[8],
				rows[i].v[7], rows[i].v[21], rows[i].v[20], rows[i].v[4:0]};
			chk("data pins", data_pin_driver_off, p);
			f = {serial_mode, serial_clock_pin_conflict, output_mode_legal};
			chk("mode flags", f, rows[i].e);
			host.rd(8'h0B, q);
			chk("readback", q, {1'b1, rows[i].v[15:8]});
		end
		pd_case(8'h08, 3'b010, 200, 70);
		pd_case(8'h06, 3'b101, 900, 110);
		host.wr(8'h0A, 8'hFF);
		serial_input_clock_enable_aux = 1'b1;
		tick(2);
		chk("receiver", serial_input_clock_receiver_on, 1'b1);
		chk("data clock", data_clock_out_driver_off, 1'b0);
		serial_input_clock_enable_aux = 1'b0;
		data_clock_out_powerdown = 1'b1;
		host.wr(8'h0A, 8'h00);
		tick(2);
		chk("receiver", serial_input_clock_receiver_on, 1'b0);
		chk("data clock", data_clock_out_driver_off, 1'b1);
		host.wr(8'h0E, 8'hAF);
		g = {pin_sync_select, register_sync_trigger, register_sync_enable,
			reference_control_source, reference_select,
			single_ended_clock_enable};
		chk("sync fields", g, 7'h5F);
		host.wr(8'h0E, 8'hEF);
		n = 0;
		repeat (5) begin
			n += (register_sync_pulse === 1'b1);
			tick(1);
		end
		chk("sync pulses", 24'(n), 24'h000001);
		ce = 1'b0;
		host.wr(8'h0A, 8'h55);
		ce = 1'b1;
		host.rd(8'h0A, q);
		chk("frozen write", q, 9'h100);
		host.rd(8'h0F, q);
		chk("unmapped", q, 9'h100);
		rst_n = 1'b0;
		tick(4);
		rst_n = 1'b1;
		for (i = 10; i < 15; i++) begin
			host.rd(8'(i), q);
			chk("reset value", q, 9'h100);
		end
		conclude();
	end
endmodule : obp_regs_tb_top
